// ==== hw/puxm_pkg.sv ====
// Package with operation codes, unit codes and field constants for the datapath.
package puxm_pkg;
  typedef enum logic [2:0] {
    PUXM_OP_NONE,
    PUXM_OP_UNPACK_LOW_BYTES,
    PUXM_OP_XOR_REG,
    PUXM_OP_XOR_CONST,
    PUXM_OP_EXPAND_HALFWORD,
    PUXM_OP_EXPAND_BYTE
  } puxm_op_t;

  typedef enum logic [1:0] {
    PUXM_UNIT_L,
    PUXM_UNIT_S,
    PUXM_UNIT_D,
    PUXM_UNIT_M
  } puxm_unit_t;

  localparam int PUXM_DATA_W = 32;
  localparam int PUXM_REG_ADDR_W = 5;
  localparam int PUXM_CONST_W = 5;
  localparam int PUXM_HALF_W = 16;
  localparam int PUXM_BYTE_W = 8;
  localparam int PUXM_HALF_LANES = 2;
  localparam int PUXM_BYTE_LANES = 4;
  localparam logic [31:0] PUXM_ZERO_WORD = 32'h0000_0000;
  localparam logic [4:0] PUXM_ZERO_ADDR = 5'h00;
  localparam logic [2:0] PUXM_ZERO_OP = 3'h0;
endpackage

// ==== hw/puxm_datapath.sv ====
// Execute-stage datapath for unpack, exclusive-OR and mask expansion operations.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Source byte 1 goes to destination byte 2.
// - Source byte 0 stays in destination byte 0.
// - Unpack zero-fills each lane's high byte.
// - Exclusive-OR accepted on L, S, D units.
// - Exclusive-OR result identical on every unit.
// - Halfword expand reads only source bits 1..0.
// - Source bit 1 fills upper halfword.
// - Source bit 0 fills lower halfword.
// - Halfword expand ignores source bits 31..2.
// - Halfword expand on multiply unit, one delay slot.
// - Byte expand reads only source bits 3..0.
// - Source bit n fills destination byte n.
module puxm_datapath
  import puxm_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic ISSUE,
  input wire puxm_op_t OP,
  input wire puxm_unit_t UNIT,
  input wire logic PRED,
  input wire logic [PUXM_DATA_W-1:0] FIRST_SOURCE_OPERAND,
  input wire logic [PUXM_CONST_W-1:0] SIGNED_5BIT_CONSTANT,
  input wire logic [PUXM_DATA_W-1:0] SECOND_SOURCE_OPERAND,
  input wire logic [PUXM_REG_ADDR_W-1:0] DST_ADDR,
  output logic WB_EN,
  output logic [PUXM_REG_ADDR_W-1:0] WB_ADDR,
  output logic [PUXM_DATA_W-1:0] WB_DATA,
  output logic ILLEGAL
);

  ////////////////////////////////////////////////////////////////////////////////
  // Operation decode and result functions.

  function automatic logic is_single_cycle(input puxm_op_t op);
    is_single_cycle = (op == PUXM_OP_UNPACK_LOW_BYTES) || (op == PUXM_OP_XOR_REG) ||
                      (op == PUXM_OP_XOR_CONST);
  endfunction

  function automatic logic is_two_cycle(input puxm_op_t op);
    is_two_cycle = (op == PUXM_OP_EXPAND_HALFWORD) || (op == PUXM_OP_EXPAND_BYTE);
  endfunction

  // Mask expansion only lives on the multiply unit; the other ops never use it.
  function automatic logic unit_ok(input puxm_op_t op, input puxm_unit_t unit);
    unit_ok = 1'b0;
    unique case (op)
      PUXM_OP_UNPACK_LOW_BYTES: unit_ok = (unit == PUXM_UNIT_L) || (unit == PUXM_UNIT_S);
      PUXM_OP_XOR_REG, PUXM_OP_XOR_CONST: unit_ok = (unit != PUXM_UNIT_M);
      PUXM_OP_EXPAND_HALFWORD, PUXM_OP_EXPAND_BYTE: unit_ok = (unit == PUXM_UNIT_M);
      PUXM_OP_NONE: unit_ok = 1'b0;
      default: unit_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [PUXM_DATA_W-1:0] unpack_low(input logic [PUXM_DATA_W-1:0] s);
    unpack_low = {{PUXM_BYTE_W{1'b0}}, s[2*PUXM_BYTE_W-1:PUXM_BYTE_W],
                  {PUXM_BYTE_W{1'b0}}, s[PUXM_BYTE_W-1:0]};
  endfunction

  function automatic logic [PUXM_DATA_W-1:0] sext_const(input logic [PUXM_CONST_W-1:0] c);
    sext_const = {{(PUXM_DATA_W-PUXM_CONST_W){c[PUXM_CONST_W-1]}}, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Single-cycle results, shared by every unit so the result cannot differ.

  logic [PUXM_DATA_W-1:0] xor_lhs;
  logic [PUXM_DATA_W-1:0] fast_result;
  logic [PUXM_DATA_W-1:0] half_mask;
  logic [PUXM_DATA_W-1:0] byte_mask;
  logic legal;

  assign legal = unit_ok(OP, UNIT);
  assign xor_lhs = (OP == PUXM_OP_XOR_CONST) ? sext_const(SIGNED_5BIT_CONSTANT)
                                             : FIRST_SOURCE_OPERAND;
  assign fast_result = (OP == PUXM_OP_UNPACK_LOW_BYTES) ? unpack_low(SECOND_SOURCE_OPERAND)
                                                        : (xor_lhs ^ SECOND_SOURCE_OPERAND);

  genvar gi;
  generate
    for (gi = 0; gi < PUXM_HALF_LANES; gi++) begin : g_half
      assign half_mask[gi*PUXM_HALF_W +: PUXM_HALF_W] =
        {PUXM_HALF_W{SECOND_SOURCE_OPERAND[gi]}};
    end
    for (gi = 0; gi < PUXM_BYTE_LANES; gi++) begin : g_byte
      assign byte_mask[gi*PUXM_BYTE_W +: PUXM_BYTE_W] =
        {PUXM_BYTE_W{SECOND_SOURCE_OPERAND[gi]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Multiply-unit stage: expansion result is held one cycle, giving one delay slot.

  logic mul_vld_r;
  logic [PUXM_REG_ADDR_W-1:0] mul_addr_r;
  logic [PUXM_DATA_W-1:0] mul_data_r;
  logic mul_vld_nxt;

  // A predicate that is false turns the issue into a no-op with no write.
  assign mul_vld_nxt = ISSUE && PRED && legal && is_two_cycle(OP);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mul_vld_r <= 1'b0;
      mul_addr_r <= PUXM_ZERO_ADDR;
      mul_data_r <= PUXM_ZERO_WORD;
    end else begin
      mul_vld_r <= mul_vld_nxt;
      mul_addr_r <= DST_ADDR;
      mul_data_r <= (OP == PUXM_OP_EXPAND_HALFWORD) ? half_mask : byte_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write-back port. The multiply unit and a single-cycle unit are separate units
  // and may both finish in one cycle; the decoder must not target one write port
  // with both, so here the older multiply result takes the port.

  logic fast_vld;
  assign fast_vld = ISSUE && PRED && legal && is_single_cycle(OP);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_EN <= 1'b0;
      WB_ADDR <= PUXM_ZERO_ADDR;
      WB_DATA <= PUXM_ZERO_WORD;
    end else if (mul_vld_r) begin
      WB_EN <= 1'b1;
      WB_ADDR <= mul_addr_r;
      WB_DATA <= mul_data_r;
    end else if (fast_vld) begin
      WB_EN <= 1'b1;
      WB_ADDR <= DST_ADDR;
      WB_DATA <= fast_result;
    end else begin
      WB_EN <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ILLEGAL <= 1'b0;
    end else begin
      ILLEGAL <= ISSUE && (OP != PUXM_OP_NONE) && !legal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_UNPACK_ONE_CYCLE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_UNPACK_LOW_BYTES && !mul_vld_r |=>
      WB_EN && WB_DATA == {8'h00, $past(SECOND_SOURCE_OPERAND[15:8]),
                           8'h00, $past(SECOND_SOURCE_OPERAND[7:0])})
    else $error("Unpack result or timing wrong.");

  AST_UNPACK_HIGH_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_UNPACK_LOW_BYTES && !mul_vld_r |=>
      WB_DATA[31:24] == 8'h00 && WB_DATA[15:8] == 8'h00)
    else $error("Unpack high bytes not zero.");

  AST_XOR_CONST: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_XOR_CONST && !mul_vld_r |=>
      WB_EN && WB_DATA == ($past(SECOND_SOURCE_OPERAND) ^
        {{27{$past(SIGNED_5BIT_CONSTANT[4])}}, $past(SIGNED_5BIT_CONSTANT)}))
    else $error("Constant exclusive-OR result wrong.");

  AST_XOR_ANY_UNIT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && OP == PUXM_OP_XOR_REG && UNIT != PUXM_UNIT_M && !mul_vld_r |=>
      WB_EN && WB_DATA == ($past(FIRST_SOURCE_OPERAND) ^ $past(SECOND_SOURCE_OPERAND)))
    else $error("Register exclusive-OR refused or wrong.");

  AST_HALF_EXPAND: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_HALFWORD |-> ##2
      WB_EN && WB_DATA == {{16{$past(SECOND_SOURCE_OPERAND[1], 2)}},
                           {16{$past(SECOND_SOURCE_OPERAND[0], 2)}}})
    else $error("Halfword mask wrong or not two cycles after issue.");

  AST_BYTE_EXPAND: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_BYTE |-> ##2
      WB_EN && WB_DATA == {{8{$past(SECOND_SOURCE_OPERAND[3], 2)}},
        {8{$past(SECOND_SOURCE_OPERAND[2], 2)}}, {8{$past(SECOND_SOURCE_OPERAND[1], 2)}},
        {8{$past(SECOND_SOURCE_OPERAND[0], 2)}}})
    else $error("Byte mask wrong or not two cycles after issue.");

  AST_NO_WRITE_FALSE_PRED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!ISSUE || !PRED) && !mul_vld_r |=> !WB_EN)
    else $error("Write-back with false predicate.");

  AST_EXPAND_DELAY_SLOT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && is_two_cycle(OP) && !mul_vld_r && !fast_vld ##1
      !fast_vld |-> !WB_EN ##1 WB_EN)
    else $error("Expansion result appeared in its delay slot.");

  ////////////////////////////////////////////////////////////////////////////////
  // Lane, address and refusal checks.

  AST_UNPACK_LOW_KEEP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_UNPACK_LOW_BYTES && !mul_vld_r |=>
      WB_DATA[7:0] == $past(SECOND_SOURCE_OPERAND[7:0]))
    else $error("Unpack low byte not kept.");

  AST_UNPACK_MOVE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_UNPACK_LOW_BYTES && !mul_vld_r |=>
      WB_DATA[23:16] == $past(SECOND_SOURCE_OPERAND[15:8]))
    else $error("Unpack second byte not moved.");

  AST_XOR_DATA_UNIT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && OP == PUXM_OP_XOR_REG && UNIT == PUXM_UNIT_D && !mul_vld_r |=>
      WB_EN && WB_DATA == ($past(FIRST_SOURCE_OPERAND) ^ $past(SECOND_SOURCE_OPERAND)))
    else $error("Exclusive-OR on data unit differs.");

  AST_HALF_UPPER: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_HALFWORD |-> ##2
      WB_DATA[31:16] == {16{$past(SECOND_SOURCE_OPERAND[1], 2)}})
    else $error("Upper halfword mask wrong.");

  AST_HALF_LOWER: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_HALFWORD |-> ##2
      WB_DATA[15:0] == {16{$past(SECOND_SOURCE_OPERAND[0], 2)}})
    else $error("Lower halfword mask wrong.");

  AST_HALF_SOLID: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_HALFWORD |-> ##2
      (WB_DATA[31:16] == 16'h0000 || WB_DATA[31:16] == 16'hffff) &&
      (WB_DATA[15:0] == 16'h0000 || WB_DATA[15:0] == 16'hffff))
    else $error("Halfword mask lane not solid.");

  AST_BYTE_SOLID: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_BYTE |-> ##2
      (WB_DATA[31:24] == 8'h00 || WB_DATA[31:24] == 8'hff) &&
      (WB_DATA[7:0] == 8'h00 || WB_DATA[7:0] == 8'hff))
    else $error("Byte mask lane not solid.");

  AST_BYTE_TOP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_BYTE |-> ##2
      WB_DATA[31:24] == {8{$past(SECOND_SOURCE_OPERAND[3], 2)}})
    else $error("Top byte mask wrong.");

  AST_BYTE_BOTTOM: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && OP == PUXM_OP_EXPAND_BYTE |-> ##2
      WB_DATA[7:0] == {8{$past(SECOND_SOURCE_OPERAND[0], 2)}})
    else $error("Bottom byte mask wrong.");

  AST_FAST_WB_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    fast_vld && !mul_vld_r |=>
      WB_EN && WB_ADDR == $past(DST_ADDR))
    else $error("Single-cycle write-back address wrong.");

  AST_EXPAND_WB_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && PRED && legal && is_two_cycle(OP) |-> ##2
      WB_EN && WB_ADDR == $past(DST_ADDR, 2))
    else $error("Expansion write-back address wrong.");

  AST_PRED_FALSE_NO_MUL: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && !PRED |=>
      !mul_vld_r)
    else $error("False predicate started an expansion.");

  AST_ILLEGAL_NO_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && OP != PUXM_OP_NONE && !legal && !mul_vld_r |=>
      ILLEGAL && !WB_EN)
    else $error("Refused unit wrote back or gave no flag.");

  AST_XOR_NOT_ILLEGAL: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ISSUE && (OP == PUXM_OP_XOR_REG || OP == PUXM_OP_XOR_CONST) && UNIT != PUXM_UNIT_M |=>
      !ILLEGAL)
    else $error("Exclusive-OR refused on an allowed unit.");

  AST_WB_ONE_CYCLE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    WB_EN && !mul_vld_r && !fast_vld |=>
      !WB_EN)
    else $error("Write-back strobe stood too long.");

  AST_WB_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !mul_vld_r && !fast_vld |=>
      $stable(WB_DATA) && $stable(WB_ADDR))
    else $error("Write-back data moved without a write.");

endmodule
`default_nettype wire

// ==== testbench/puxm_regfile.sv ====
// Register file model that takes the datapath's write-back.
`timescale 1ns/1ps
`default_nettype none
module puxm_regfile
  import puxm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [PUXM_REG_ADDR_W-1:0] waddr,
  input wire logic [PUXM_DATA_W-1:0] wdata,
  input wire logic [PUXM_REG_ADDR_W-1:0] raddr,
  output logic [PUXM_DATA_W-1:0] rdata
);
  logic [PUXM_DATA_W-1:0] mem_r [32];
  // Cleared on reset so a register that was never written reads as zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        mem_r[i] <= PUXM_ZERO_WORD;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end
  assign rdata = mem_r[raddr];
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the execute-stage datapath.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import puxm_pkg::*;
;
  typedef struct packed {
    puxm_op_t op;
    puxm_unit_t unit;
    logic [31:0] a;
    logic [4:0] k;
    logic [31:0] b;
    logic [31:0] e;
  } puxm_row_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic issue = 1'b0;
  logic pred = 1'b0;
  puxm_op_t op = PUXM_OP_NONE;
  puxm_unit_t unit = PUXM_UNIT_L;
  logic [31:0] a = 32'h0;
  logic [31:0] b = 32'h0;
  logic [4:0] k = 5'h0;
  logic [4:0] dst = 5'h0;
  logic [4:0] raddr = 5'h0;
  logic wb_en;
  logic ill;
  logic [4:0] wb_addr;
  logic [31:0] wb_data;
  logic [31:0] rdata;
  int err_total = 0;
  int checks = 0;
  puxm_row_t rows [10] = '{
    '{PUXM_OP_UNPACK_LOW_BYTES, PUXM_UNIT_L, 32'h0, 5'h0, 32'h9e526e30, 32'h006e0030},
    '{PUXM_OP_UNPACK_LOW_BYTES, PUXM_UNIT_S, 32'h0, 5'h0, 32'hffffffff, 32'h00ff00ff},
    '{PUXM_OP_XOR_REG, PUXM_UNIT_L, 32'h0721325a, 5'h0, 32'h00190f12, 32'h07383d48},
    '{PUXM_OP_XOR_REG, PUXM_UNIT_S, 32'h0721325a, 5'h0, 32'h00190f12, 32'h07383d48},
    '{PUXM_OP_XOR_REG, PUXM_UNIT_D, 32'h0721325a, 5'h0, 32'h00190f12, 32'h07383d48},
    '{PUXM_OP_XOR_CONST, PUXM_UNIT_D, 32'h0, 5'h0d, 32'h00001023, 32'h0000102e},
    '{PUXM_OP_XOR_CONST, PUXM_UNIT_S, 32'h0, 5'h10, 32'h0000000f, 32'hffffffff},
    '{PUXM_OP_EXPAND_HALFWORD, PUXM_UNIT_M, 32'h0, 5'h0, 32'hb1746ca1, 32'h0000ffff},
    '{PUXM_OP_EXPAND_HALFWORD, PUXM_UNIT_M, 32'h0, 5'h0, 32'hfffffffe, 32'hffff0000},
    '{PUXM_OP_EXPAND_BYTE, PUXM_UNIT_M, 32'h0, 5'h0, 32'hfffffff5, 32'h00ff00ff}
  };
  always #50 sys_clk = ~sys_clk;
  puxm_datapath dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .ISSUE(issue), .OP(op), .UNIT(unit),
    .PRED(pred), .FIRST_SOURCE_OPERAND(a), .SIGNED_5BIT_CONSTANT(k), .SECOND_SOURCE_OPERAND(b),
    .DST_ADDR(dst), .WB_EN(wb_en), .WB_ADDR(wb_addr), .WB_DATA(wb_data), .ILLEGAL(ill));
  puxm_regfile rf (.clk(sys_clk), .rst_b(rst_b), .we(wb_en), .waddr(wb_addr),
    .wdata(wb_data), .raddr(raddr), .rdata(rdata));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic send(input puxm_row_t r, input logic p, input logic [4:0] d);
    @(posedge sys_clk);
    issue <= 1'b1;
    {op, unit, a, k, b} <= {r.op, r.unit, r.a, r.k, r.b};
    pred <= p;
    dst <= d;
    @(posedge sys_clk);
    issue <= 1'b0;
    #1;
  endtask
  task automatic check_row(input int i);
    send(rows[i], 1'b1, 5'(i + 1));
    // Mask expansion answers one edge later than the single-cycle operations.
    if (rows[i].unit == PUXM_UNIT_M) begin
      chk("early_wb_en", 32'h0, 32'(wb_en));
      @(posedge sys_clk);
      #1;
    end
    chk("wb_en", 32'h1, 32'(wb_en));
    chk("wb_data", rows[i].e, wb_data);
    chk("wb_addr", 32'(i + 1), 32'(wb_addr));
    @(posedge sys_clk);
    #1;
    chk("wb_en_drop", 32'h0, 32'(wb_en));
    raddr = 5'(i + 1);
    #1;
    chk("reg", rows[i].e, rdata);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    chk("rst_out", 32'h0, {wb_data[31:1], wb_en | ill | (|wb_addr) | wb_data[0]});
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      check_row(i);
    end
    send(rows[2], 1'b0, 5'd1);
    chk("pred_off", 32'h0, 32'(wb_en | ill));
    raddr = 5'd1;
    #1;
    chk("pred_reg", rows[0].e, rdata);
    send('{PUXM_OP_XOR_REG, PUXM_UNIT_M, 32'h1, 5'h0, 32'h2, 32'h0}, 1'b1, 5'd4);
    chk("illegal", 32'h1, {wb_en, ill});
    @(posedge sys_clk);
    issue <= 1'b1;
    op <= PUXM_OP_UNPACK_LOW_BYTES;
    unit <= PUXM_UNIT_L;
    pred <= 1'b1;
    b <= 32'h9e526e30;
    dst <= 5'd7;
    @(posedge sys_clk);
    b <= 32'h0000a55a;
    dst <= 5'd8;
    #1;
    chk("b2b_first", 32'h006e0030, wb_data);
    @(posedge sys_clk);
    issue <= 1'b0;
    #1;
    chk("b2b_second", 32'h00a5005a, wb_data);
    chk("b2b_addr", 32'h8, 32'(wb_addr));
    results();
  end
endmodule
`default_nettype wire
